// *** src/pcft_top.sv ***
/*
 * pcft_top: configuration-space extension registers, bus watchdogs
 * and microframe length control of a host controller function.
 * Assumes one configuration request at a time, synchronous inputs,
 * and a bus monitor that flags transaction start, TRDY wait, retry.
 */
// Operation
// R1: read/write target-ready timeout byte at 40h, reset 00h, 00h disables
// R2: target-ready limit is 13 bits: byte in upper 8, low 5 zero
// R3: target-ready timeout counts PCI clock cycles
// R4: TRDY held off beyond limit sets the unrecoverable error flag
// R5: read/write retry timeout byte at 41h, reset 00h, 00h disables
// R6: retries beyond the retry limit set the unrecoverable error flag
// R7: release number byte at 60h reads constant 20h
// R8: trim register at 61h: six writable bits, bits 7..6 reserved
// R9: software writes reserved trim bits as zero
// R10: microframe lasts 59488 plus trim counter clock periods
// R11: trim resets to 20h, giving 59520 periods
// R12: new trim value applies to following microframes
// R13: 16-bit wake mask at 62h, reset 0007h, no effect on operation
// R14: capability base plus zero reads identifier 01h
// R15: only one capability entry carries identifier 01h
// R16: structure layout: id +0, next +1, caps +2, csr +4, ext +6, data +7
// R17: capability pointer at 34h reads DCh
// R18: watchdog counters clear at each new bus transaction
`timescale 1ns/1ps
module pcft_top
    import pcft_pkg::*;
#(
    parameter int         SOF_BASE    = SOF_BASE_CYC,
    parameter int         SOF_W       = 16,
    parameter logic [7:0] PM_NEXT_VAL = 8'h00,
    parameter logic [15:0] PM_CAPS_VAL = 16'h0000
) (
    input  wire logic                    CORE_CLK,
    input  wire logic                    RESET_N,
    input  wire pcft_pkg::pcft_cfg_req_t CFG_REQ,
    input  wire pcft_pkg::pcft_bus_mon_t BUS_MON,
    input  wire logic                    UE_CLEAR,
    input  wire logic                    SOF_RUN,
    output pcft_pkg::pcft_cfg_rsp_t      CFG_RSP,
    output logic                         UE_FLAG,
    output logic                         SOF_PULSE,
    output logic [5:0]                   FRAME_TRIM,
    output logic [15:0]                  PORT_WAKE_MASK
);
    import pcft_pkg::*;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    initial begin
        if (SOF_BASE < 64) $error("pcft_top: SOF_BASE too small");
        if (SOF_W < 7) $error("pcft_top: SOF_W too small");
    end

    // ----------------------------------------------------------------
    // access sequencing
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        PCFT_IDLE = 1'b0,
        PCFT_RESP = 1'b1
    } pcft_state_t;

    pcft_state_t state;
    pcft_state_t next_state;

    logic [7:0]  target_ready_timeout;
    logic [7:0]  retry_timeout;
    logic [5:0]  frame_length_trim;
    logic [15:0] port_wake_mask;
    logic        unrecoverable_error_flag;
    logic        trdy_trip;
    logic        retry_trip;
    logic        sof;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic byte_hit(input logic [7:0] addr,
                                      input logic [3:0] be,
                                      input logic [7:0] ofs);
        byte_hit = (addr[7:2] == ofs[7:2]) && be[ofs[1:0]];
    endfunction

    function automatic logic dw_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
        dw_hit = (addr[7:2] == ofs[7:2]);
    endfunction

    wire take     = CFG_REQ.sel && (state == PCFT_IDLE);
    wire wr_take  = take && CFG_REQ.wr;
    wire rd_take  = take && !CFG_REQ.wr;
    wire wr_trdy  = wr_take && byte_hit(CFG_REQ.addr, CFG_REQ.be, TRDY_TO_OFS);
    wire wr_retry = wr_take && byte_hit(CFG_REQ.addr, CFG_REQ.be, RETRY_TO_OFS);
    wire wr_trim  = wr_take && byte_hit(CFG_REQ.addr, CFG_REQ.be, TRIM_OFS);
    wire wr_wk_lo = wr_take && byte_hit(CFG_REQ.addr, CFG_REQ.be, WAKE_LO_OFS);
    wire wr_wk_hi = wr_take && byte_hit(CFG_REQ.addr, CFG_REQ.be, WAKE_HI_OFS);

    wire [7:0] pm_id_ofs   = CAP_BASE + PM_ID_REL;
    wire [7:0] pm_caps_ofs = CAP_BASE + PM_CAPS_REL;
    wire [7:0] pm_csr_ofs  = CAP_BASE + PM_CSR_REL;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // capability pointer at 34h
    wire [31:0] rd_cap_ptr = {24'h00_0000, CAP_BASE};             // [R17]
    wire [31:0] rd_timeout = {16'h0000, retry_timeout,
                              target_ready_timeout};              // [R1] [R5]
    // release number, trim with reserved bits as zero, wake mask
    wire [31:0] rd_ehci    = {port_wake_mask, 2'b00,
                              frame_length_trim, REL_NUM_VAL};    // [R7] [R8]
    // single power management entry: id, next, capabilities
    wire [31:0] rd_pm_head = {PM_CAPS_VAL, PM_NEXT_VAL,
                              CAPABILITY_IDENTIFIER_VAL};                         // [R14] [R15] [R16]

    wire [31:0] next_rdata =
        dw_hit(CFG_REQ.addr, CAP_PTR_OFS) ? rd_cap_ptr :
        dw_hit(CFG_REQ.addr, TRDY_TO_OFS) ? rd_timeout :
        dw_hit(CFG_REQ.addr, REL_NUM_OFS) ? rd_ehci    :
        dw_hit(CFG_REQ.addr, pm_id_ofs)   ? rd_pm_head :
        32'h0000_0000;

    // control/status and beyond are outside this block and read zero
    wire unused_csr = dw_hit(CFG_REQ.addr, pm_csr_ofs)
                    || dw_hit(CFG_REQ.addr, pm_caps_ofs);

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_comb begin
        unique case (state)
            PCFT_IDLE: next_state = take ? PCFT_RESP : PCFT_IDLE;
            PCFT_RESP: next_state = PCFT_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state         <= PCFT_IDLE;
            CFG_RSP       <= '0;
        end else begin
            state         <= next_state;
            CFG_RSP.ack   <= take;
            CFG_RSP.rdata <= rd_take ? next_rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            target_ready_timeout <= TRDY_TO_RST;                  // [R1]
            retry_timeout        <= RETRY_TO_RST;                 // [R5]
            frame_length_trim    <= TRIM_RST;                     // [R11]
            port_wake_mask       <= WAKE_RST;                     // [R13]
        end else begin
            if (wr_trdy)
                target_ready_timeout <= CFG_REQ.wdata[7:0];       // [R1]
            if (wr_retry)
                retry_timeout <= CFG_REQ.wdata[15:8];             // [R5]
            // upper two bits dropped, software keeps them zero
            if (wr_trim)
                frame_length_trim <= CFG_REQ.wdata[13:8];         // [R8] [R9]
            if (wr_wk_lo)
                port_wake_mask[7:0] <= CFG_REQ.wdata[23:16];      // [R13]
            if (wr_wk_hi)
                port_wake_mask[15:8] <= CFG_REQ.wdata[31:24];     // [R13]
        end
    end

    // ----------------------------------------------------------------
    // watchdogs
    // ----------------------------------------------------------------
    wire [WD_W-1:0] trdy_limit  = {target_ready_timeout,
                                   {TRDY_LSB_W{1'b0}}};           // [R2]
    wire [WD_W-1:0] retry_limit = WD_W'(retry_timeout);            // [R6]

    // one tick per clock while TRDY is held off
    pcft_watchdog #(.W(WD_W)) u_trdy_wd (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .start (BUS_MON.start),                                    // [R18]
        .tick  (BUS_MON.trdy_wait),                                // [R3]
        .limit (trdy_limit),
        .trip  (trdy_trip)
    );

    pcft_watchdog #(.W(WD_W)) u_retry_wd (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .start (BUS_MON.start),                                    // [R18]
        .tick  (BUS_MON.retry),
        .limit (retry_limit),
        .trip  (retry_trip)
    );

    // set wins over clear
    wire next_ue = (unrecoverable_error_flag && !UE_CLEAR)
                 || trdy_trip || retry_trip;                       // [R4] [R6]

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            unrecoverable_error_flag <= 1'b0;
            UE_FLAG                  <= 1'b0;
            FRAME_TRIM               <= TRIM_RST;
            PORT_WAKE_MASK           <= WAKE_RST;
        end else begin
            unrecoverable_error_flag <= next_ue;
            UE_FLAG                  <= next_ue;
            FRAME_TRIM               <= frame_length_trim;
            PORT_WAKE_MASK           <= port_wake_mask;
        end
    end

    // ----------------------------------------------------------------
    // microframe timer
    // ----------------------------------------------------------------
    pcft_sof_timer #(.BASE(SOF_BASE), .W(SOF_W)) u_sof (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .run   (SOF_RUN),
        .trim  (frame_length_trim),                                // [R10] [R12]
        .sof   (sof)
    );

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N)
            SOF_PULSE <= 1'b0;
        else
            SOF_PULSE <= sof;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    logic [SOF_W-1:0] gap;
    logic             seen_sof;
    logic [5:0]       len_trim;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gap      <= '0;
            seen_sof <= 1'b0;
            len_trim <= TRIM_RST;
        end else if (!SOF_RUN) begin
            gap      <= '0;
            seen_sof <= 1'b0;
        end else if (sof) begin
            gap      <= SOF_W'(1);
            seen_sof <= 1'b1;
            len_trim <= frame_length_trim;
        end else begin
            gap      <= gap + 1'b1;
        end
    end

    sequence s_rd_req(logic [7:0] ofs);
        rd_take && dw_hit(CFG_REQ.addr, ofs);
    endsequence

    sequence s_wd_trip;
        trdy_trip || retry_trip;
    endsequence

    sequence s_ue_stays;
        UE_FLAG ##1 UE_FLAG;
    endsequence

    a_ack_one_cycle: assert property (
        take |=> CFG_RSP.ack ##1 !CFG_RSP.ack)
        else $error("answer not a single cycle");

    a_rdata_idle: assert property (
        !rd_take |=> CFG_RSP.rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_cap_ptr_read: assert property ( // [R17]
        s_rd_req(CAP_PTR_OFS) |=> CFG_RSP.rdata[7:0] == 8'hDC)
        else $error("capability pointer wrong");

    a_rel_num_read: assert property ( // [R7]
        s_rd_req(REL_NUM_OFS) |=> CFG_RSP.rdata[7:0] == 8'h20
            && CFG_RSP.rdata[15:14] == 2'b00)
        else $error("release number or reserved bits wrong");

    a_capability_identifier_read: assert property ( // [R14]
        s_rd_req(CAP_BASE) |=> CFG_RSP.rdata[7:0] == 8'h01)
        else $error("capability identifier wrong");

    a_trdy_byte_write: assert property ( // [R1]
        wr_trdy |=> target_ready_timeout == $past(CFG_REQ.wdata[7:0]))
        else $error("target-ready timeout not stored");

    a_retry_byte_write: assert property ( // [R5]
        wr_retry |=> retry_timeout == $past(CFG_REQ.wdata[15:8]))
        else $error("retry timeout not stored");

    a_trim_write: assert property ( // [R8]
        wr_trim |=> frame_length_trim == $past(CFG_REQ.wdata[13:8]))
        else $error("trim not stored");

    a_wake_write: assert property ( // [R13]
        wr_wk_lo |=> port_wake_mask[7:0] == $past(CFG_REQ.wdata[23:16]))
        else $error("wake mask not stored");

    a_trip_on_wait: assert property ( // [R3]
        trdy_trip |-> $past(BUS_MON.trdy_wait))
        else $error("target-ready trip without a wait cycle");

    a_trdy_sets_ue: assert property ( // [R4]
        trdy_trip && target_ready_timeout != 8'h00 |=> UE_FLAG)
        else $error("timeout did not raise error flag");

    a_retry_sets_ue: assert property ( // [R6]
        retry_trip |=> UE_FLAG)
        else $error("retry trip did not raise error flag");

    a_ue_no_cause: assert property ( // [R4]
        !trdy_trip && !retry_trip && !UE_FLAG |=> !UE_FLAG)
        else $error("error flag set without cause");

    a_ue_sticky: assert property ( // [R4]
        UE_FLAG && !UE_CLEAR |-> s_ue_stays)
        else $error("error flag dropped without clear");

    a_ue_clears: assert property ( // [R4]
        UE_CLEAR && !trdy_trip && !retry_trip |=> !UE_FLAG)
        else $error("error flag not cleared");

    a_wd_disabled: assert property ( // [R5]
        retry_timeout == 8'h00 && $stable(retry_timeout)
            |=> !retry_trip)
        else $error("retry watchdog fired while disabled");

    a_ue_set_wins: assert property ( // [R4]
        UE_CLEAR ##0 s_wd_trip |=> UE_FLAG)
        else $error("event lost under clear");

    a_frame_length: assert property ( // [R10]
        seen_sof && sof |-> gap == SOF_W'(SOF_BASE) + SOF_W'(len_trim))
        else $error("microframe length wrong");

    a_reset_trim: assert property ( // [R11]
        $rose(RESET_N) |-> frame_length_trim == 6'h20
            && port_wake_mask == 16'h0007)
        else $error("trim or wake mask reset value wrong");

    wire unused_ok = unused_csr;
endmodule

// *** inc/pcft_pkg.sv ***
/*
 * pcft_pkg: offsets, field layout, reset values and carrier types
 * for the configuration-space extension block.
 * Assumes dword-aligned configuration accesses with byte enables.
 */
package pcft_pkg;
    // ----------------------------------------------------------------
    // configuration offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CAP_PTR_OFS  = 8'h34;
    localparam logic [7:0] TRDY_TO_OFS  = 8'h40;
    localparam logic [7:0] RETRY_TO_OFS = 8'h41;
    localparam logic [7:0] REL_NUM_OFS  = 8'h60;
    localparam logic [7:0] TRIM_OFS     = 8'h61;
    localparam logic [7:0] WAKE_LO_OFS  = 8'h62;
    localparam logic [7:0] WAKE_HI_OFS  = 8'h63;
    localparam logic [7:0] CAP_BASE     = 8'hDC;
    localparam logic [7:0] PM_ID_REL    = 8'h00;
    localparam logic [7:0] PM_NEXT_REL  = 8'h01;
    localparam logic [7:0] PM_CAPS_REL  = 8'h02;
    localparam logic [7:0] PM_CSR_REL   = 8'h04;
    localparam logic [7:0] PM_BSE_REL   = 8'h06;
    localparam logic [7:0] PM_DATA_REL  = 8'h07;
    // ----------------------------------------------------------------
    // reset and constant values, field layout
    // ----------------------------------------------------------------
    localparam logic [7:0]  TRDY_TO_RST  = 8'h00;
    localparam logic [7:0]  RETRY_TO_RST = 8'h00;
    localparam logic [7:0]  REL_NUM_VAL  = 8'h20;
    localparam logic [5:0]  TRIM_RST     = 6'h20;
    localparam logic [15:0] WAKE_RST     = 16'h0007;
    localparam logic [7:0]  CAPABILITY_IDENTIFIER_VAL   = 8'h01;
    localparam int          TRIM_W       = 6;
    localparam int          WD_W         = 13;
    localparam int          TRDY_LSB_W   = 5;
    localparam int          SOF_BASE_CYC = 59488;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcft_cfg_req_t;
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } pcft_cfg_rsp_t;
    typedef struct packed {
        logic start;
        logic trdy_wait;
        logic retry;
    } pcft_bus_mon_t;
endpackage

// *** src/pcft_watchdog.sv ***
/*
 * pcft_watchdog: counts ticks within one bus transaction and
 * pulses when the count passes a programmed limit.
 * Assumes start marks each new transaction; limit zero disables.
 */
`timescale 1ns/1ps
module pcft_watchdog #(
    parameter int W = 13
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    output logic              trip
);
    logic [W-1:0] cnt;
    logic         done;
    wire          armed     = (limit != '0) && !done;
    wire          next_trip = armed && tick && (cnt == limit);

    initial begin
        if (W < 2) $error("pcft_watchdog: W too small");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= '0;
            done <= 1'b0;
            trip <= 1'b0;
        end else begin
            trip <= next_trip;
            if (start) begin
                cnt  <= '0;
                done <= 1'b0;
            end else if (next_trip) begin
                done <= 1'b1;
            end else if (tick && armed) begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule

// *** src/pcft_sof_timer.sv ***
/*
 * pcft_sof_timer: microframe timer, one pulse per frame of
 * BASE plus trim counter clock periods.
 * Assumes run is held high while frames are generated.
 */
`timescale 1ns/1ps
module pcft_sof_timer #(
    parameter int BASE = 59488,
    parameter int W    = 16
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [5:0] trim,
    output logic            sof
);
    logic [W-1:0] cnt;
    logic [W-1:0] len;
    wire  [W-1:0] next_len = W'(BASE) + W'(trim);
    wire          wrap     = (cnt == len - 1'b1);

    initial begin
        if (BASE + 63 >= (1 << W)) $error("pcft_sof_timer: W too small");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            len <= W'(BASE);
            sof <= 1'b0;
        end else begin
            sof <= run && wrap;
            if (!run || wrap) begin
                cnt <= '0;
                len <= next_len;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule

// *** testbench/pcft_host_model.sv ***
/*
 * pcft_host_model: host bridge side, issues configuration cycles
 * and flags bus transaction events to the block.
 * Assumes a free clock; drives its outputs at the falling edge.
 */
`timescale 1ns/1ps
module pcft_host_model (
    input  wire logic                    clk,
    input  wire pcft_pkg::pcft_cfg_rsp_t rsp,
    output pcft_pkg::pcft_cfg_req_t      req,
    output pcft_pkg::pcft_bus_mon_t      mon
);
    import pcft_pkg::*;
    // ----------------------------------------------------------------
    // configuration cycle, held until ack or for at most 8 clocks
    // ----------------------------------------------------------------
    initial begin
        req = '{sel: 1'b0, wr: 1'b0, addr: 8'hA5, be: 4'h5, wdata: 32'h5A5A_A5A5};
        mon = '0;
    end
    task automatic cfg(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                       input logic [31:0] wdata, output logic [31:0] rdata,
                       output logic ok);
        int n;
        ok = 1'b0;
        rdata = '0;
        @(negedge clk);
        req <= '{sel: 1'b1, wr: wr, addr: addr, be: be, wdata: wdata};
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge clk);
            if (rsp.ack === 1'b1) begin
                ok = 1'b1;
                rdata = rsp.rdata;
            end
        end
        @(negedge clk);
        // released lines show the inverse, not the last value
        req <= '{sel: 1'b0, wr: ~wr, addr: ~addr, be: ~be, wdata: ~wdata};
    endtask
    // ----------------------------------------------------------------
    // one bus transaction: start, wait cycles, retry pulses
    // ----------------------------------------------------------------
    task automatic txn(input int waits, input int retries);
        @(negedge clk);
        mon <= '{start: 1'b1, trdy_wait: 1'b0, retry: 1'b0};
        repeat (waits) begin
            @(negedge clk);
            mon <= '{start: 1'b0, trdy_wait: 1'b1, retry: 1'b0};
        end
        repeat (retries) begin
            @(negedge clk);
            mon <= '{start: 1'b0, trdy_wait: 1'b0, retry: 1'b1};
        end
        @(negedge clk);
        mon <= '0;
    endtask
endmodule

// *** testbench/tb_top.sv ***
/*
 * tb_top: self-checking bench for the configuration extension block.
 * Assumes the host model drives requests; short microframe base.
 */
`timescale 1ns/1ps
module tb_top;
    import pcft_pkg::*;
    localparam int          SOF_B  = 100;
    localparam logic [7:0]  NEXT_V = 8'h00;
    localparam logic [15:0] CAPS_V = 16'h0000;
    logic          core_clk;
    logic          reset_n;
    logic          ue_clear;
    logic          sof_run;
    pcft_cfg_req_t req;
    pcft_bus_mon_t mon;
    pcft_cfg_rsp_t rsp;
    logic          ue_flag;
    logic          sof_pulse;
    logic [5:0]    frame_trim;
    logic [15:0]   wake;
    int            fails;
    int            total_checks;
    // ----------------------------------------------------------------
    // instances
    // ----------------------------------------------------------------
    pcft_top #(.SOF_BASE(SOF_B), .SOF_W(16), .PM_NEXT_VAL(NEXT_V), .PM_CAPS_VAL(CAPS_V)) uut (
        .CORE_CLK      (core_clk),
        .RESET_N       (reset_n),
        .CFG_REQ       (req),
        .BUS_MON       (mon),
        .UE_CLEAR      (ue_clear),
        .SOF_RUN       (sof_run),
        .CFG_RSP       (rsp),
        .UE_FLAG       (ue_flag),
        .SOF_PULSE     (sof_pulse),
        .FRAME_TRIM    (frame_trim),
        .PORT_WAKE_MASK(wake)
    );
    pcft_host_model host (.clk(core_clk), .rsp(rsp), .req(req), .mon(mon));
    always #5 core_clk = ~core_clk;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        host.cfg(1'b0, a, 4'hF, 32'h0000_0000, d, ok);
        check({31'h0, ok}, 32'h0000_0001, "read ack");
        check(d, exp, "read data");
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        logic [31:0] d;
        logic        ok;
        host.cfg(1'b1, a, be, v, d, ok);
        check({31'h0, ok}, 32'h0000_0001, "write ack");
    endtask
    task automatic ue_is(input logic exp);
        repeat (4) @(negedge core_clk);
        check({31'h0, ue_flag}, {31'h0, exp}, "error flag");
    endtask
    task automatic ue_drop;
        @(negedge core_clk);
        ue_clear = 1'b1;
        @(negedge core_clk);
        ue_clear = 1'b0;
        ue_is(1'b0);
    endtask
    task automatic sof_gap(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (sof_pulse !== 1'b1 && n < 400);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        check({26'h0, frame_trim}, 32'h0000_0020, "trim out");
        check({16'h0, wake}, 32'h0000_0007, "wake out");
        check({31'h0, ue_flag}, 32'h0000_0000, "flag out");
        rd(8'h40, 32'h0000_0000);
        rd(8'h60, 32'h0007_2020);
        rd(8'h34, 32'h0000_00DC);
        rd(8'hDC, {CAPS_V, NEXT_V, 8'h01});
        rd(8'h44, 32'h0000_0000);
    endtask
    task automatic t_regs;
        wr(8'h40, 4'h3, 32'hFFFF_5AA5);
        rd(8'h40, 32'h0000_5AA5);
        wr(8'h60, 4'hF, 32'hFFFF_3F55);
        rd(8'h60, 32'hFFFF_3F20);
        check({26'h0, frame_trim}, 32'h0000_003F, "trim out");
        check({16'h0, wake}, 32'h0000_FFFF, "wake out");
        wr(8'h60, 4'h4, 32'h00AB_0000);
        rd(8'h60, 32'hFFAB_3F20);
        wr(8'h34, 4'hF, 32'hFFFF_FFFF);
        wr(8'hDC, 4'hF, 32'hFFFF_FFFF);
        rd(8'h34, 32'h0000_00DC);
        rd(8'hDC, {CAPS_V, NEXT_V, 8'h01});
    endtask
    task automatic t_trdy;
        wr(8'h40, 4'h3, 32'h0000_0001);
        host.txn(32, 0);
        ue_is(1'b0);
        host.txn(20, 0);
        host.txn(20, 0);
        ue_is(1'b0);
        host.txn(33, 0);
        ue_is(1'b1);
        ue_drop();
        wr(8'h40, 4'h1, 32'h0000_0000);
        host.txn(300, 0);
        ue_is(1'b0);
    endtask
    task automatic t_retry;
        wr(8'h40, 4'h3, 32'h0000_0200);
        host.txn(0, 2);
        host.txn(0, 2);
        ue_is(1'b0);
        host.txn(0, 3);
        ue_is(1'b1);
        ue_drop();
        ue_clear = 1'b1;
        host.txn(0, 3);
        @(negedge core_clk);
        check({31'h0, ue_flag}, 32'h0000_0001, "set under clear");
        ue_clear = 1'b0;
        ue_drop();
        wr(8'h40, 4'h2, 32'h0000_0000);
        host.txn(0, 10);
        ue_is(1'b0);
    endtask
    task automatic t_sof;
        int n;
        wr(8'h60, 4'h2, 32'h0000_2000);
        sof_run = 1'b1;
        sof_gap(n);
        sof_gap(n);
        check(n, SOF_B + 32, "frame length");
        wr(8'h60, 4'h2, 32'h0000_0000);
        sof_gap(n);
        sof_gap(n);
        check(n, SOF_B, "frame length");
        wr(8'h60, 4'h2, 32'h0000_3F00);
        sof_gap(n);
        sof_gap(n);
        check(n, SOF_B + 63, "frame length");
        sof_run = 1'b0;
    endtask
    task automatic t_again;
        wr(8'h40, 4'h3, 32'h0000_0101);
        @(negedge core_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        check({26'h0, frame_trim}, 32'h0000_0020, "trim out");
        check({16'h0, wake}, 32'h0000_0007, "wake out");
        rd(8'h40, 32'h0000_0000);
        rd(8'h60, 32'h0007_2020);
    endtask
    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        conclude();
    end
    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        ue_clear = 1'b0;
        sof_run = 1'b0;
        fails = 0;
        total_checks = 0;
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        t_reset();
        t_regs();
        t_trdy();
        t_retry();
        t_sof();
        t_again();
        conclude();
    end
endmodule
